// ---- hdl/bpmr_pkg.sv ----
`default_nettype none
package bpmr_pkg;
  // Field widths
  localparam int unsigned OFF_W   = 16;
  localparam int unsigned SLOT_W  = 8;
  localparam int unsigned CD_W    = 8;
  localparam int unsigned MAS_W   = 8;
  localparam int unsigned RND_W   = 16;

  // Start offset code that announces a halted relocation
  localparam logic [OFF_W-1:0]  HALT_OFF      = 16'hFFFF;

  // Reset values and LFSR feedback taps
  localparam logic [CD_W-1:0]   CD_RST        = 8'h00;
  localparam logic [OFF_W-1:0]  OFF_RST       = 16'h0000;
  localparam logic [SLOT_W-1:0] SLOT_RST      = 8'h00;
  localparam logic [MAS_W-1:0]  MAS_RST       = 8'h00;
  localparam logic [RND_W-1:0]  LFSR_SEED     = 16'hACE1;
  localparam logic [RND_W-1:0]  LFSR_TAPS     = 16'hB400;

  // Field positions in the random word
  localparam int unsigned RND_WAIT_LSB = 0;
  localparam int unsigned RND_SIG_LSB  = 8;

  // MAS slot size as a power of two, in microseconds
  localparam int unsigned MAS_SHIFT = 8;
endpackage
`default_nettype wire

// ---- hdl/bpmr_lfsr.sv ----
`default_nettype none
module bpmr_lfsr
  import bpmr_pkg::*;
(
  input  wire logic             mclk_in,
  input  wire logic             reset_in,
  output logic [RND_W-1:0]      rnd_out
);
  typedef struct packed {
    logic [RND_W-1:0] lfsr;
  } bpmr_lfsr_st_t;

  bpmr_lfsr_st_t s_q;
  bpmr_lfsr_st_t s_d;

  // Galois form, steps every clock so draws stay decorrelated
  always_comb begin
    s_d = s_q;
    if (s_q.lfsr[0]) begin
      s_d.lfsr = (s_q.lfsr >> 1) ^ LFSR_TAPS;
    end else begin
      s_d.lfsr = s_q.lfsr >> 1;
    end
  end

  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      s_q.lfsr <= LFSR_SEED;
    end else begin
      s_q <= s_d;
    end
  end

  assign rnd_out = s_q.lfsr;
endmodule
`default_nettype wire

// ---- hdl/bpmr_merge.sv ----
// Function
// - Reserve non-overlapping alien period, extra slot
// - Reservation tracks largest alien BP length
// - Start relocation within wait; not if switched
// - Listen during reserved alien slots
// - New switch: initial countdown, largest offset
// - New slot offset: zero or computed
// - Far alien start: recompute all fields
// - Near alien start: refresh, raise, count
// - Adopt neighbour switch next superframe
// - Adopted slot offset: zero or larger
// - Neighbour offset far beyond: copy all
// - Near neighbour, larger slot: copy all
// - Three conditions: copy offset, decrement
// - No update condition: hold, decrement countdown
// - Keep switch until move or halt
// - Halt when alien moves sooner
// - Halt element: max offset, zero, initial
// - Halt reaches zero: drop, keep slot
// - Countdown zero: shift start, drop elements
// - New slot prior plus offset, else join
// - Random signaling-slot delay after move
// - Extend BP length for alien switch
// - Aligned only within twice guard time
`default_nettype none
module bpmr_merge
  import bpmr_pkg::*;
#(
  parameter int unsigned GUARD_US   = 12,
  parameter int unsigned INIT_CD    = 3,
  parameter int unsigned SIG_SLOTS  = 2,
  parameter int unsigned MAX_BP_LEN = 96,
  parameter int unsigned WAIT_SF    = 16,
  parameter int unsigned SLOT_US    = 85
)
(
  input  wire logic                  mclk_in,
  input  wire logic                  reset_in,
  input  wire logic                  sf_end_in,
  input  wire logic                  normal_join_in,
  input  wire logic [SLOT_W-1:0]     own_slot_in,
  input  wire logic [SLOT_W-1:0]     own_bp_len_in,
  input  wire logic                  rx_valid_in,
  input  wire logic                  rx_sig_slot_in,
  input  wire logic                  rx_overlap_in,
  input  wire logic [OFF_W-1:0]      rx_start_diff_in,
  input  wire logic [SLOT_W-1:0]     rx_bp_len_in,
  input  wire logic [SLOT_W-1:0]     rx_high_slot_in,
  input  wire logic                  rx_has_switch_in,
  input  wire logic [CD_W-1:0]       rx_sw_cd_in,
  input  wire logic [OFF_W-1:0]      rx_sw_off_in,
  input  wire logic [SLOT_W-1:0]     rx_sw_slot_in,
  output logic                       drp_alien_en_out,
  output logic [MAS_W-1:0]           drp_alien_first_out,
  output logic [MAS_W-1:0]           drp_alien_count_out,
  output logic                       listen_alien_out,
  output logic                       reloc_active_out,
  output logic                       sw_present_out,
  output logic [CD_W-1:0]            sw_cd_out,
  output logic [OFF_W-1:0]           sw_off_out,
  output logic [SLOT_W-1:0]          sw_slot_out,
  output logic                       move_out,
  output logic [OFF_W-1:0]           move_adjust_out,
  output logic [SLOT_W-1:0]          move_slot_out,
  output logic                       move_join_out,
  output logic                       sig_hold_out,
  output logic [SLOT_W-1:0]          bp_len_out
);
  localparam logic [OFF_W:0]  GUARD2   = (OFF_W+1)'(2 * GUARD_US);
  localparam logic [CD_W-1:0] INIT_C   = CD_W'(INIT_CD);
  localparam logic [SLOT_W-1:0] SIGC   = SLOT_W'(SIG_SLOTS);
  localparam logic [SLOT_W-1:0] MAXBP  = SLOT_W'(MAX_BP_LEN);
  localparam logic [SLOT_W-1:0] WAIT1  = SLOT_W'(WAIT_SF);
  localparam logic [SLOT_W-1:0] WAIT15 = SLOT_W'((3 * WAIT_SF) / 2);

  typedef struct packed {
    logic              sw_on;
    logic              halting;
    logic [CD_W-1:0]   cd;
    logic [OFF_W-1:0]  off;
    logic [SLOT_W-1:0] slot;
    logic              drp_on;
    logic [MAS_W-1:0]  drp_first;
    logic [MAS_W-1:0]  drp_cnt;
    logic              pend;
    logic [SLOT_W-1:0] wait_sf;
    logic              reloc;
    logic [SLOT_W-1:0] ext_len;
    logic              a_seen;
    logic [OFF_W-1:0]  a_off;
    logic [SLOT_W-1:0] a_high;
    logic [SLOT_W-1:0] a_len;
    logic              a_sw;
    logic              a_sooner;
    logic              a_target;
    logic              n_seen;
    logic [CD_W-1:0]   n_cd;
    logic [OFF_W-1:0]  n_off;
    logic [SLOT_W-1:0] n_slot;
    logic              move;
    logic [OFF_W-1:0]  adj;
    logic [SLOT_W-1:0] new_slot;
    logic              join_n;
    logic              sig_pick;
    logic [SLOT_W-1:0] sig_lim;
    logic [SLOT_W-1:0] sig_wait;
  } bpmr_st_t;

  bpmr_st_t         s_q;
  bpmr_st_t         s_d;
  logic [RND_W-1:0] rnd;

  bpmr_lfsr u_rnd (
    .mclk_in  (mclk_in),
    .reset_in (reset_in),
    .rnd_out  (rnd)
  );

  // One plus highest occupied slot minus signaling slots, floored at 0
  function automatic logic [SLOT_W-1:0] slot_calc(
    input logic [SLOT_W-1:0] high
  );
    logic [SLOT_W:0] t;
    t = {1'b0, high} + (SLOT_W+1)'(1);
    if (t > {1'b0, SIGC}) begin
      slot_calc = SLOT_W'(t - {1'b0, SIGC});
    end else begin
      slot_calc = SLOT_RST;
    end
  endfunction

  function automatic logic [SLOT_W-1:0] max_slot(
    input logic [SLOT_W-1:0] a,
    input logic [SLOT_W-1:0] b
  );
    max_slot = (a > b) ? a : b;
  endfunction

  // Absolute difference of two offsets, one bit wider
  function automatic logic [OFF_W:0] off_dist(
    input logic [OFF_W-1:0] a,
    input logic [OFF_W-1:0] b
  );
    off_dist = (a > b) ? {1'b0, a} - {1'b0, b} : {1'b0, b} - {1'b0, a};
  endfunction

  logic              rx_aligned;
  logic              rx_alien;
  logic [OFF_W-1:0]  neg_diff;
  logic [SLOT_W-1:0] a_slot;
  logic [SLOT_W-1:0] n_slot_new;
  logic [OFF_W+8:0]  a_end_us;
  logic [SLOT_W:0]   ext_sum;

  always_comb begin
    neg_diff   = OFF_W'(~rx_start_diff_in + OFF_W'(1));
    // Wrap-aware, the diff is modulo one superframe
    rx_aligned = ({1'b0, rx_start_diff_in} < GUARD2) ||
                 ({1'b0, neg_diff} < GUARD2);
    // Signaling-slot beacons are never alien
    rx_alien   = rx_valid_in && !rx_aligned && !rx_sig_slot_in;
    a_slot     = normal_join_in ? SLOT_RST : slot_calc(s_q.a_high);
    n_slot_new = normal_join_in ? SLOT_RST :
                 max_slot(slot_calc(s_q.a_high), s_q.n_slot);
    a_end_us   = (OFF_W+9)'(s_q.a_off) +
                 (OFF_W+9)'(s_q.a_len) * (OFF_W+9)'(SLOT_US);
    ext_sum    = {1'b0, rx_sw_slot_in} + {1'b0, rx_bp_len_in};
  end

  always_comb begin
    s_d      = s_q;
    s_d.move = 1'b0;

    if (sf_end_in) begin
      // Alien reservation, refreshed each superframe that saw a non-overlapping alien beacon
      if (s_q.a_seen) begin
        s_d.drp_on    = 1'b1;
        s_d.drp_first = MAS_W'(s_q.a_off >> MAS_SHIFT);
        // Whole MAS span, boundary mismatch adds a slot
        s_d.drp_cnt   = MAS_W'((a_end_us - (OFF_W+9)'(1)) >> MAS_SHIFT)
                        - MAS_W'(s_q.a_off >> MAS_SHIFT)
                        + MAS_W'(1);
        // A switched alien period never opens the wait
        if (!s_q.pend && !s_q.reloc && !s_q.a_sw) begin
          s_d.pend    = 1'b1;
          // Random start inside the allowed window
          s_d.wait_sf = SLOT_W'(rnd[RND_WAIT_LSB +: SLOT_W]) %
                        (s_q.a_off[OFF_W-1] ? WAIT15 : WAIT1);
        end
      end
      if (s_q.pend && !s_q.reloc) begin
        if (s_q.a_sw) begin
          s_d.pend = 1'b0;
        end else if (s_q.wait_sf == SLOT_RST) begin
          s_d.reloc = 1'b1;
        end else begin
          s_d.wait_sf = s_q.wait_sf - SLOT_W'(1);
        end
      end

      if (s_q.sw_on && s_q.cd == CD_RST) begin
        s_d.sw_on   = 1'b0;
        s_d.halting = 1'b0;
        s_d.reloc   = 1'b0;
        s_d.pend    = 1'b0;
        s_d.drp_on  = 1'b0;
        s_d.ext_len = SLOT_RST;
        if (!s_q.halting) begin
          s_d.move     = 1'b1;
          s_d.adj      = s_q.off;
          s_d.new_slot = own_slot_in + s_q.slot;
          s_d.join_n   = (s_q.slot == SLOT_RST) ||
                         ({1'b0, own_slot_in} + {1'b0, s_q.slot} >=
                          {1'b0, MAXBP});
          s_d.sig_pick = 1'b1;
          s_d.sig_lim  = own_bp_len_in;
        end
        // Halted: slot and sync untouched, element dropped
      end else if (s_q.sw_on && s_q.a_sooner && !s_q.halting) begin
        s_d.halting = 1'b1;
        s_d.off     = HALT_OFF;
        s_d.slot    = SLOT_RST;
        s_d.cd      = INIT_C;
      end else if (s_q.n_seen && !s_q.sw_on) begin
        s_d.sw_on = 1'b1;
        s_d.cd    = s_q.n_cd;
        s_d.off   = s_q.n_off;
        s_d.slot  = n_slot_new;
      end else if (s_q.n_seen &&
                   ({1'b0, s_q.n_off} > {1'b0, s_q.off} + GUARD2 ||
                    (off_dist(s_q.n_off, s_q.off) < GUARD2 &&
                     s_q.n_slot > s_q.slot))) begin
        s_d.cd   = s_q.n_cd;
        s_d.off  = s_q.n_off;
        s_d.slot = n_slot_new;
      end else if (s_q.n_seen && off_dist(s_q.n_off, s_q.off) < GUARD2 &&
                   !s_q.a_target && s_q.n_cd < s_q.cd) begin
        s_d.off = s_q.n_off;
        s_d.cd  = s_q.cd - CD_W'(1);
      end else if (s_q.a_seen && s_q.reloc && !s_q.sw_on) begin
        s_d.sw_on = 1'b1;
        s_d.cd    = INIT_C;
        s_d.off   = s_q.a_off;
        s_d.slot  = a_slot;
      end else if (s_q.a_seen && s_q.reloc &&
                   {1'b0, s_q.a_off} > {1'b0, s_q.off} + GUARD2) begin
        s_d.cd   = INIT_C;
        s_d.off  = s_q.a_off;
        s_d.slot = a_slot;
      end else if (s_q.a_seen && s_q.reloc &&
                   off_dist(s_q.a_off, s_q.off) < GUARD2) begin
        s_d.off = s_q.a_off;
        if (a_slot > s_q.slot) begin
          s_d.slot = a_slot;
          s_d.cd   = INIT_C;
        end else begin
          s_d.cd = s_q.cd - CD_W'(1);
        end
      end else if (s_q.sw_on) begin
        s_d.cd = s_q.cd - CD_W'(1);
      end

      // Signaling-slot delay counts whole superframes
      if (!s_q.sig_pick && s_q.sig_wait != SLOT_RST) begin
        s_d.sig_wait = s_q.sig_wait - SLOT_W'(1);
      end

      // Per-superframe observations start afresh
      s_d.a_seen   = 1'b0;
      s_d.a_off    = OFF_RST;
      s_d.a_high   = SLOT_RST;
      s_d.a_len    = SLOT_RST;
      s_d.a_sw     = 1'b0;
      s_d.a_sooner = 1'b0;
      s_d.a_target = 1'b0;
      s_d.n_seen   = 1'b0;
    end

    // Rejection draw keeps the delay uniform over 0..limit
    if (s_q.sig_pick && !s_d.move) begin
      if (rnd[RND_SIG_LSB +: SLOT_W] <= s_q.sig_lim) begin
        s_d.sig_wait = rnd[RND_SIG_LSB +: SLOT_W];
        s_d.sig_pick = 1'b0;
      end
    end

    if (rx_alien && !rx_overlap_in) begin
      s_d.a_seen = 1'b1;
      if (!s_d.a_seen || rx_start_diff_in > s_d.a_off) begin
        s_d.a_off = rx_start_diff_in;
      end
      s_d.a_high = max_slot(s_d.a_high, rx_high_slot_in);
      s_d.a_len  = max_slot(s_d.a_len, rx_bp_len_in);
      if (off_dist(rx_start_diff_in, s_q.off) < GUARD2) begin
        s_d.a_target = 1'b1;
      end
    end
    if (rx_alien && rx_has_switch_in) begin
      s_d.a_sw = 1'b1;
      if (s_q.sw_on && rx_sw_cd_in < s_q.cd) begin
        s_d.a_sooner = 1'b1;
      end
      if (rx_sw_slot_in != SLOT_RST) begin
        // Extension never shrinks until countdown zero clears it, and stops at the maximum
        s_d.ext_len = max_slot(s_q.ext_len,
                      (ext_sum > {1'b0, MAXBP}) ? MAXBP
                                                : SLOT_W'(ext_sum));
      end
    end
    if (rx_valid_in && rx_aligned && rx_has_switch_in) begin
      // Keep the farthest move heard; larger slot breaks ties
      if (!s_d.n_seen || rx_sw_off_in > s_d.n_off ||
          (rx_sw_off_in == s_d.n_off && rx_sw_slot_in > s_d.n_slot)) begin
        s_d.n_cd   = rx_sw_cd_in;
        s_d.n_off  = rx_sw_off_in;
        s_d.n_slot = rx_sw_slot_in;
      end
      s_d.n_seen = 1'b1;
    end
  end

  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign drp_alien_en_out    = s_q.drp_on;
  assign drp_alien_first_out = s_q.drp_first;
  assign drp_alien_count_out = s_q.drp_cnt;
  assign listen_alien_out    = s_q.drp_on;
  assign reloc_active_out    = s_q.reloc;
  assign sw_present_out      = s_q.sw_on;
  assign sw_cd_out           = s_q.cd;
  assign sw_off_out          = s_q.off;
  assign sw_slot_out         = s_q.slot;
  assign move_out            = s_q.move;
  assign move_adjust_out     = s_q.adj;
  assign move_slot_out       = s_q.new_slot;
  assign move_join_out       = s_q.join_n;
  assign sig_hold_out        = s_q.sig_pick || (s_q.sig_wait != SLOT_RST);
  assign bp_len_out          = max_slot(own_bp_len_in, s_q.ext_len);
endmodule
`default_nettype wire

// ---- tb/bpmr_merge_chk.sv ----
`default_nettype none
module bpmr_merge_chk
  import bpmr_pkg::*;
#(
  parameter int unsigned MAX_BP_LEN = 96
)
(
  input wire logic                         mclk_in,
  input wire logic                         reset_in,
  input wire logic                         sf_end_in,
  input wire logic [bpmr_pkg::SLOT_W-1:0]  own_bp_len_in,
  input wire logic                         drp_alien_en_out,
  input wire logic                         listen_alien_out,
  input wire logic                         sw_present_out,
  input wire logic [bpmr_pkg::CD_W-1:0]    sw_cd_out,
  input wire logic [bpmr_pkg::OFF_W-1:0]   sw_off_out,
  input wire logic [bpmr_pkg::SLOT_W-1:0]  sw_slot_out,
  input wire logic                         move_out,
  input wire logic [bpmr_pkg::SLOT_W-1:0]  move_slot_out,
  input wire logic                         move_join_out,
  input wire logic [bpmr_pkg::SLOT_W-1:0]  bp_len_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (reset_in);

  sequence s_cd_zero;
    sw_present_out && sw_cd_out == 8'h00 && sf_end_in;
  endsequence
  // Answer may land one or two edges after the superframe end
  sequence s_sf_recent;
    $past(sf_end_in) || $past(sf_end_in, 2);
  endsequence

  AST_LISTEN: assert property (listen_alien_out == drp_alien_en_out)
    else $error("listen differs from reservation");
  AST_DRP_SF: assert property ($rose(drp_alien_en_out) |-> s_sf_recent)
    else $error("reservation rose outside superframe end");
  AST_SW_HOLD: assert property ($changed(sw_off_out) |-> s_sf_recent)
    else $error("switch offset changed mid superframe");
  AST_MOVE: assert property (s_cd_zero ##0 sw_off_out != HALT_OFF
    |-> ##[1:2] move_out) else $error("no move at countdown zero");
  AST_HALT_END: assert property (s_cd_zero ##0 sw_off_out == HALT_OFF
    |=> !move_out ##1 (!move_out && !sw_present_out))
    else $error("halt end moved or kept switch");
  AST_ONE: assert property (move_out |=> !move_out)
    else $error("move pulse longer than one cycle");
  AST_KEEP: assert property ($fell(sw_present_out)
    |-> $past(sw_cd_out) == 8'h00) else $error("switch dropped early");
  AST_HALT_FORM: assert property (sw_present_out && sw_off_out == HALT_OFF
    |-> sw_slot_out == 8'h00) else $error("halt slot offset not zero");
  AST_SLOT: assert property (move_out && !move_join_out
    |-> move_slot_out < MAX_BP_LEN) else $error("move slot out of range");
  AST_BP_LEN: assert property (bp_len_out >= own_bp_len_in &&
    (bp_len_out <= MAX_BP_LEN || bp_len_out == own_bp_len_in))
    else $error("bp length out of range");
  AST_MOVE_DROP: assert property (move_out
    |-> ##[0:1] (!sw_present_out && !drp_alien_en_out))
    else $error("elements kept after move");
endmodule

bind bpmr_merge bpmr_merge_chk #(.MAX_BP_LEN(MAX_BP_LEN)) chk_u (
  .mclk_in, .reset_in, .sf_end_in, .own_bp_len_in, .drp_alien_en_out,
  .listen_alien_out, .sw_present_out, .sw_cd_out, .sw_off_out,
  .sw_slot_out, .move_out, .move_slot_out, .move_join_out, .bp_len_out
);
`default_nettype wire

// ---- tb/bpmr_nbr.sv ----
`default_nettype none
module bpmr_nbr
  import bpmr_pkg::*;
(
  input  wire logic                    mclk_in,
  output logic                         rx_valid_out,
  output logic [bpmr_pkg::OFF_W-1:0]   rx_start_diff_out,
  output logic [bpmr_pkg::SLOT_W-1:0]  rx_bp_len_out,
  output logic [bpmr_pkg::SLOT_W-1:0]  rx_high_slot_out,
  output logic                         rx_has_switch_out,
  output logic [bpmr_pkg::CD_W-1:0]    rx_sw_cd_out,
  output logic [bpmr_pkg::OFF_W-1:0]   rx_sw_off_out,
  output logic [bpmr_pkg::SLOT_W-1:0]  rx_sw_slot_out
);
  logic [64:0] fld = '0;

  initial rx_valid_out = 1'b0;
  assign {rx_start_diff_out, rx_bp_len_out, rx_high_slot_out,
          rx_has_switch_out, rx_sw_cd_out, rx_sw_off_out,
          rx_sw_slot_out} = fld;

  // Fields are inverted after the frame, so a design must not reuse them
  task automatic beacon(input logic [15:0] d, input logic [7:0] len,
                        input logic [7:0] hi, input logic sw,
                        input logic [7:0] cd, input logic [15:0] off,
                        input logic [7:0] sl);
    @(posedge mclk_in);
    rx_valid_out <= 1'b1;
    fld <= {d, len, hi, sw, cd, off, sl};
    @(posedge mclk_in);
    rx_valid_out <= 1'b0;
    fld <= ~{d, len, hi, sw, cd, off, sl};
  endtask
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
`default_nettype none
module tb_top
  import bpmr_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int ICD  = 3;
  localparam int WAIT = 16;

  logic              mclk_in        = 1'b0;
  logic              reset_in       = 1'b1;
  logic              sf_end_in      = 1'b0;
  logic              normal_join_in = 1'b0;
  logic [SLOT_W-1:0] own_slot_in    = 8'h05;
  logic [SLOT_W-1:0] own_bp_len_in  = 8'h06;
  logic              rx_sig_slot_in = 1'b0;
  logic              rx_overlap_in  = 1'b0;
  logic              rx_valid_out, rx_has_switch_out, mv_seen = 1'b0;
  logic [OFF_W-1:0]  rx_start_diff_out, rx_sw_off_out, sw_off_out;
  logic [OFF_W-1:0]  move_adjust_out, mv_adj;
  logic [SLOT_W-1:0] rx_bp_len_out, rx_high_slot_out, rx_sw_slot_out;
  logic [SLOT_W-1:0] sw_slot_out, move_slot_out, bp_len_out, mv_slot;
  logic [CD_W-1:0]   rx_sw_cd_out, sw_cd_out;
  logic              drp_alien_en_out, listen_alien_out, reloc_active_out;
  logic              sw_present_out, move_out, move_join_out, sig_hold_out;
  logic              mv_join, mv_hold;
  logic [MAS_W-1:0]  drp_alien_first_out, drp_alien_count_out;
  int                n_fail = 0;
  int                n_tests = 0;

  always #5 mclk_in = ~mclk_in;

  bpmr_merge #(.INIT_CD(ICD), .WAIT_SF(WAIT)) dut_u (
    .mclk_in, .reset_in, .sf_end_in, .normal_join_in, .own_slot_in,
    .own_bp_len_in, .rx_valid_in(rx_valid_out), .rx_sig_slot_in,
    .rx_overlap_in, .rx_start_diff_in(rx_start_diff_out),
    .rx_bp_len_in(rx_bp_len_out), .rx_high_slot_in(rx_high_slot_out),
    .rx_has_switch_in(rx_has_switch_out), .rx_sw_cd_in(rx_sw_cd_out),
    .rx_sw_off_in(rx_sw_off_out), .rx_sw_slot_in(rx_sw_slot_out),
    .drp_alien_en_out, .drp_alien_first_out, .drp_alien_count_out,
    .listen_alien_out, .reloc_active_out, .sw_present_out, .sw_cd_out,
    .sw_off_out, .sw_slot_out, .move_out, .move_adjust_out,
    .move_slot_out, .move_join_out, .sig_hold_out, .bp_len_out
  );
  bpmr_nbr nbr_u (
    .mclk_in, .rx_valid_out, .rx_start_diff_out, .rx_bp_len_out,
    .rx_high_slot_out, .rx_has_switch_out, .rx_sw_cd_out,
    .rx_sw_off_out, .rx_sw_slot_out
  );

  // Move is a one-cycle pulse; latch it for later checks
  always @(posedge mclk_in) begin
    if (reset_in) begin
      mv_seen <= 1'b0;
    end else if (move_out === 1'b1) begin
      mv_seen <= 1'b1;
      mv_adj  <= move_adjust_out;
      mv_slot <= move_slot_out;
      mv_join <= move_join_out;
      mv_hold <= sig_hold_out;
    end
  end

  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic sw(input logic [7:0] cd, input logic [15:0] off,
                    input logic [7:0] sl);
    chk("sw_present", 16'h0001, 16'(sw_present_out));
    chk("sw_cd", 16'(cd), 16'(sw_cd_out));
    chk("sw_off", off, sw_off_out);
    chk("sw_slot", 16'(sl), 16'(sw_slot_out));
  endtask

  task automatic sf;
    @(posedge mclk_in);
    sf_end_in <= 1'b1;
    @(posedge mclk_in);
    sf_end_in <= 1'b0;
    repeat (2) @(posedge mclk_in);
    #1;
  endtask

  task automatic rst;
    @(posedge mclk_in);
    reset_in <= 1'b1;
    repeat (8) @(posedge mclk_in);
    #1;
    chk("sw_present", 16'h0000, 16'(sw_present_out));
    chk("drp_alien_en", 16'h0000, 16'(drp_alien_en_out));
    chk("bp_len", 16'(own_bp_len_in), 16'(bp_len_out));
    @(posedge mclk_in);
    reset_in       <= 1'b0;
    normal_join_in <= 1'b0;
  endtask

  task automatic alien(input logic [15:0] d);
    nbr_u.beacon(d, 8'h0A, 8'h05, 1'b0, 8'h00, 16'h0000, 8'h00);
    nbr_u.beacon(d - 16'h0010, 8'h03, 8'h02, 1'b0, 8'h00, 16'h0000, 8'h00);
  endtask

  task automatic t_adopt;
    nbr_u.beacon(16'h0000, 8'h04, 8'h03, 1'b1, 8'h05, 16'h0300, 8'h03);
    sf();
    sw(8'h05, 16'h0300, 8'h03);
    nbr_u.beacon(16'h0000, 8'h04, 8'h03, 1'b1, 8'h04, 16'h0305, 8'h06);
    sf();
    sw(8'h04, 16'h0305, 8'h06);
    @(posedge mclk_in);
    normal_join_in <= 1'b1;
    nbr_u.beacon(16'h0000, 8'h04, 8'h03, 1'b1, 8'h07, 16'h0400, 8'h01);
    sf();
    sw(8'h07, 16'h0400, 8'h00);
    sf();
    sw(8'h06, 16'h0400, 8'h00);
    nbr_u.beacon(16'h0000, 8'h04, 8'h03, 1'b1, 8'h02, 16'h0402, 8'h00);
    sf();
    sw(8'h05, 16'h0402, 8'h00);
  endtask

  task automatic t_halt;
    int i;
    nbr_u.beacon(16'h2000, 8'h0A, 8'h03, 1'b1, 8'h01, 16'h1000, 8'h04);
    sf();
    sw(8'(ICD), HALT_OFF, 8'h00);
    chk("bp_len", 16'h000E, 16'(bp_len_out));
    for (i = ICD - 1; i >= 0; i--) begin
      sf();
      sw(8'(i), HALT_OFF, 8'h00);
    end
    sf();
    chk("sw_present", 16'h0000, 16'(sw_present_out));
    chk("move_seen", 16'h0000, 16'(mv_seen));
  endtask

  task automatic t_move;
    int k;
    nbr_u.beacon(16'h0017, 8'h04, 8'h03, 1'b0, 8'h00, 16'h0000, 8'h00);
    nbr_u.beacon(16'hFFE9, 8'h04, 8'h03, 1'b0, 8'h00, 16'h0000, 8'h00);
    // Signaling-slot and overlapping beacons must not start a merge
    rx_sig_slot_in <= 1'b1;
    alien(16'h0400);
    rx_sig_slot_in <= 1'b0;
    rx_overlap_in  <= 1'b1;
    alien(16'h0400);
    rx_overlap_in  <= 1'b0;
    sf();
    chk("drp_alien_en", 16'h0000, 16'(drp_alien_en_out));
    for (k = 0; k <= WAIT && reloc_active_out !== 1'b1; k++) begin
      alien(16'h0400);
      sf();
    end
    chk("drp_alien_en", 16'h0001, 16'(drp_alien_en_out));
    chk("listen", 16'h0001, 16'(listen_alien_out));
    chk("drp_first", 16'h0004, 16'(drp_alien_first_out));
    chk("drp_count", 16'h0004, 16'(drp_alien_count_out));
    chk("reloc", 16'h0001, 16'(reloc_active_out));
    alien(16'h0400);
    sf();
    sw(8'(ICD), 16'h0400, 8'h04);
    for (k = ICD - 1; k >= 0; k--) begin
      alien(16'h0404);
      sf();
      sw(8'(k), 16'h0404, 8'h04);
    end
    sf();
    chk("move_seen", 16'h0001, 16'(mv_seen));
    chk("move_adjust", 16'h0404, mv_adj);
    chk("move_slot", 16'h0009, 16'(mv_slot));
    chk("move_join", 16'h0000, 16'(mv_join));
    chk("sig_hold_at_move", 16'h0001, 16'(mv_hold));
    chk("sw_present", 16'h0000, 16'(sw_present_out));
    chk("drp_alien_en", 16'h0000, 16'(drp_alien_en_out));
    for (k = 0; k < 64 && sig_hold_out !== 1'b0; k++) sf();
    chk("sig_hold", 16'h0000, 16'(sig_hold_out));
  endtask

  task automatic wrap_up;
    if (n_fail == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    rst();
    t_adopt();
    t_halt();
    rst();
    t_move();
    wrap_up();
  end

  // Whole run is at most about 520 cycles; this limit is 20000 cycles, over thirty times that
  initial begin
    #200_000;
    n_fail++;
    wrap_up();
  end
endmodule
`default_nettype wire
